// *** hdl/real_mode_unit.v ***
`timescale 1ns/1ns
`include "real_mode_map.vh"
// One request per cycle on req_valid, answer one cycle later; halt and shutdown held internally.
module real_mode_unit
(
   input wire clock,
   input wire rst,
   input wire clock_enable,
   input wire req_valid,
   input wire [1:0] req_kind,
   input wire [15:0] segment_value,
   input wire [31:0] effective_address,
   input wire [2:0] access_size,
   input wire addr32_prefix,
   input wire operand32_prefix,
   input wire is_code_fetch,
   input wire is_stack_ref,
   input wire far_transfer,
   input wire atomic_prefix,
   input wire [3:0] op_form,
   input wire mem_is_dest,
   input wire rep_prefix,
   input wire [1:0] io_privilege_level,
   input wire halt_instruction,
   input wire [15:0] next_code_offset,
   input wire stack_push_kind,
   input wire [15:0] stack_pointer,
   input wire [15:0] idt_limit,
   input wire fault_request,
   input wire [7:0] fault_vector,
   input wire nmi_pin,
   input wire maskable_interrupt_input,
   input wire interrupt_enable,
   output reg [31:0] phys_address,
   output reg [17:0] word_address_lines,
   output reg [3:0] byte_enable_lines,
   output reg [11:0] upper_address_lines,
   output reg address_valid,
   output reg bus_locked,
   output reg operand_32,
   output reg exception_valid,
   output reg [7:0] exception_vector,
   output reg [15:0] code_pointer_pair,
   output reg [19:0] vector_address,
   output reg halted,
   output reg shutdown,
   output reg bus_released,
   output reg paging_enabled,
   output reg real_mode
);
   localparam KIND_ACCESS = 2'd0;
   localparam KIND_ATOMIC_RD = 2'd1;
   localparam KIND_ATOMIC_WR = 2'd2;
   localparam KIND_INTERRUPT = 2'd3;
   localparam ST_RUN = 2'd0;
   localparam ST_HALT = 2'd1;
   localparam ST_SHUT = 2'd2;

   reg [1:0] state;
   reg [1:0] next_state;
   reg first_far_seen;
   reg nmi_meta;
   reg nmi_sync;
   reg nmi_prev;
   reg maskable_interrupt_input_meta;
   reg maskable_interrupt_input_sync;
   reg lock_hold;

   function [31:0] phys_of;
      input [15:0] seg;
      input [15:0] ofs;
      begin
         phys_of = {12'h000, {4'h0, seg} << `SEG_SHIFT} + {16'h0000, ofs};
      end
   endfunction

   function atomic_legal;
      input [3:0] form;
      input dest;
      input rep;
      begin
         case (form)
            `OP_BTS, `OP_BTR, `OP_BTC, `OP_ALU, `OP_UNARY:
               atomic_legal = dest & ~rep;
            `OP_EXCHANGE_OP:
               atomic_legal = ~rep;
            default:
               atomic_legal = 1'b0;
         endcase
      end
   endfunction

   function [3:0] lanes;
      input [1:0] low;
      input [2:0] size;
      reg [3:0] mask;
      begin
         case (size)
            3'd2: mask = 4'h3;
            3'd4, 3'd5, 3'd6, 3'd7: mask = 4'hf;
            default: mask = 4'h1;
         endcase
         lanes = mask << low;
      end
   endfunction

   function beyond_limit;
      input [7:0] vec;
      input [15:0] limit;
      begin
         // Last byte of the four-byte entry must still sit inside the table
         beyond_limit = ({vec, 2'b11} > {2'b00, limit});
      end
   endfunction

   wire [32:0] last_byte = {1'b0, effective_address} + {30'h0, access_size} - 33'h1;
   wire overrun = (last_byte > {17'h0, `SEG_LIMIT}) | (access_size == 3'd0);
   wire ea32_bad = addr32_prefix & (effective_address >= {16'h0, `SEG_LIMIT});
   wire [31:0] lin = phys_of(segment_value, effective_address[15:0]);
   wire lock_ok = atomic_legal(op_form, mem_is_dest, rep_prefix);
   wire nmi_edge = nmi_sync & ~nmi_prev;
   wire stack_wrap = stack_push_kind & stack_pointer[0] & (stack_pointer < 16'h0002);
   wire vec_out = beyond_limit(fault_vector, idt_limit);
   wire double_out = beyond_limit(`EXC_DOUBLE, idt_limit);
   wire general_out = beyond_limit(`EXC_GENERAL, idt_limit);
   wire raise_general = (req_kind == KIND_ACCESS) & (overrun | ea32_bad) & ~is_stack_ref;
   wire raise_double = (req_kind == KIND_INTERRUPT) & vec_out;
   // An exception 13 or 8 whose own vector is missing has no handler to run, so the unit stops
   wire fatal_fault = (raise_general & general_out) | (raise_double & double_out);
   wire nmi_exit_ok = (idt_limit >= `NMI_LIMIT_MIN) & (stack_pointer > `NMI_SP_MIN);
   wire wake = nmi_edge | (maskable_interrupt_input_sync & interrupt_enable);

   always @*
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (req_valid & stack_wrap)
               next_state = ST_SHUT;
            else if (req_valid & fatal_fault)
               next_state = ST_SHUT;
            else if (fault_request & vec_out & (fault_vector == `EXC_DOUBLE | fault_vector == `EXC_GENERAL))
               next_state = ST_SHUT;
            else if (halt_instruction)
               next_state = ST_HALT;
         ST_HALT:
            if (wake)
               next_state = ST_RUN;
         ST_SHUT:
            if (nmi_edge & nmi_exit_ok)
               next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
   end

   // Both pins are asynchronous; the first stage feeds no logic, and NMI edge detection also uses a third stage
   always @(posedge clock)
   begin
      if (rst)
      begin
         nmi_meta <= 1'b0;
         nmi_sync <= 1'b0;
         nmi_prev <= 1'b0;
         maskable_interrupt_input_meta <= 1'b0;
         maskable_interrupt_input_sync <= 1'b0;
      end
      else if (clock_enable)
      begin
         nmi_meta <= nmi_pin;
         nmi_sync <= nmi_meta;
         nmi_prev <= nmi_sync;
         maskable_interrupt_input_meta <= maskable_interrupt_input;
         maskable_interrupt_input_sync <= maskable_interrupt_input_meta;
      end
   end

   // Mode bits are fixed: this unit only ever runs real-address mode
   always @(posedge clock)
   begin
      if (rst)
      begin
         state <= ST_RUN;
         halted <= 1'b0;
         shutdown <= 1'b0;
         bus_released <= 1'b0;
         paging_enabled <= 1'b0;
         real_mode <= 1'b1;
      end
      else if (clock_enable)
      begin
         state <= next_state;
         halted <= (next_state == ST_HALT);
         shutdown <= (next_state == ST_SHUT);
         bus_released <= (next_state != ST_RUN);
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         first_far_seen <= 1'b0;
         lock_hold <= 1'b0;
         phys_address <= 32'h0;
         word_address_lines <= 18'h0;
         byte_enable_lines <= 4'h0;
         upper_address_lines <= 12'hfff;
         address_valid <= 1'b0;
         bus_locked <= 1'b0;
         operand_32 <= 1'b0;
         exception_valid <= 1'b0;
         exception_vector <= 8'h0;
         code_pointer_pair <= 16'h0;
         vector_address <= 20'h0;
      end
      else if (clock_enable)
      begin
         exception_valid <= 1'b0;
         address_valid <= 1'b0;
         operand_32 <= operand32_prefix;
         if (state == ST_HALT && wake)
         begin
            code_pointer_pair <= next_code_offset;
            exception_valid <= 1'b1;
            exception_vector <= nmi_edge ? `NMI_VECTOR : 8'h00;
         end
         else if (state == ST_SHUT && nmi_edge && nmi_exit_ok)
         begin
            exception_valid <= 1'b1;
            exception_vector <= `NMI_VECTOR;
         end
         else if (state == ST_RUN && req_valid && next_state == ST_RUN)
         begin
            if (far_transfer)
               first_far_seen <= 1'b1;
            case (req_kind)
               KIND_INTERRUPT:
                  if (vec_out)
                  begin
                     exception_valid <= 1'b1;
                     exception_vector <= `EXC_DOUBLE;
                  end
                  else
                  begin
                     vector_address <= {10'h0, fault_vector, 2'b00};
                     // The vector fetch goes out on the bus like any other read
                     phys_address <= {22'h0, fault_vector, 2'b00};
                     word_address_lines <= {10'h0, fault_vector};
                     byte_enable_lines <= 4'hf;
                     upper_address_lines <= 12'h000;
                     address_valid <= 1'b1;
                  end
               KIND_ATOMIC_RD, KIND_ATOMIC_WR:
                  if (!lock_ok)
                  begin
                     exception_valid <= 1'b1;
                     exception_vector <= `EXC_INVALID_OP;
                     lock_hold <= 1'b0;
                     bus_locked <= 1'b0;
                  end
                  else
                  begin
                     lock_hold <= (req_kind == KIND_ATOMIC_RD);
                     bus_locked <= 1'b1;
                     address_valid <= 1'b1;
                     phys_address <= lin;
                     word_address_lines <= lin[19:2];
                     byte_enable_lines <= lanes(lin[1:0], access_size);
                  end
               default:
                  if (overrun | ea32_bad)
                  begin
                     exception_valid <= 1'b1;
                     exception_vector <= is_stack_ref ? `EXC_STACK : `EXC_GENERAL;
                  end
                  else
                  begin
                     // No access-type or overlap check in real mode
                     address_valid <= 1'b1;
                     phys_address <= lin;
                     word_address_lines <= lin[19:2];
                     byte_enable_lines <= lanes(lin[1:0], access_size);
                     upper_address_lines <= (is_code_fetch & ~first_far_seen & ~far_transfer) ? 12'hfff : 12'h000;
                  end
            endcase
         end
         if (!(state == ST_RUN && req_valid && req_kind != KIND_ACCESS && req_kind != KIND_INTERRUPT))
            bus_locked <= lock_hold & (state == ST_RUN);
         if (next_state != ST_RUN)
            lock_hold <= 1'b0;
      end
   end
   // Exceptions 10, 11 and 14 have no source here, so they can never be reported
endmodule // real_mode_unit

// *** pkg/real_mode_map.vh ***
// Summary of operation
// - Reset leaves the unit in real mode, no paging, segment-shift addressing.
// - Default operand size is 16 bits; 32-bit only with override prefixes.
// - Segments are 64K; 32-bit effective addresses must stay below FFFFH.
// - Atomic prefix legal only on listed read-modify-write memory-destination forms.
// - Atomic prefix on any other form, including string repeats, raises exception 6.
// - Permitted atomic forms hold the bus locked across read, modify and write.
// - Atomic prefix legality ignores the I/O privilege level.
// - Memory is 1 megabyte; only address bits up to 19 and byte enables active.
// - Upper address lines stay high on code fetches until first far jump or call.
// - Physical address is segment shifted left four plus effective address.
// - Linear address is used unchanged as physical address; no paging.
// - All segments readable, writable, executable; overlap is never checked.
// - Operand or fetch crossing offset FFFFH raises exception 13; atomic requests skip this check and go out on the bus.
// - Interrupt vectors are fetched from 00000H to 003FFH, four bytes each.
// - Exceptions 10, 11 and 14 never occur in real mode.
// - Halt stops execution and frees the bus; ended by NMI, enabled MASKABLE_INTERRUPT_INPUT, reset.
// - Interrupt leaving halt saves a code pointer after the halt instruction.
// - Exception 8 or 13 with vector beyond table limit enters shutdown.
// - Call, software interrupt or push wrapping the stack with odd pointer shuts down.
// - NMI leaves shutdown only if limit at least 0017H and stack pointer above 0005H.
// - Interrupt vector outside table limit raises exception 8, return before instruction.
// - Stack reference beyond FFFFH raises exception 12, return before instruction.
`ifndef REAL_MODE_MAP_VH
`define REAL_MODE_MAP_VH
`define SEG_LIMIT 16'hffff
`define VECTOR_TOP 20'h003ff
`define NMI_LIMIT_MIN 16'h0017
`define NMI_SP_MIN 16'h0005
`define NMI_VECTOR 8'h02
`define EXC_INVALID_OP 8'h06
`define EXC_DOUBLE 8'h08
`define EXC_STACK 8'h0c
`define EXC_GENERAL 8'h0d
`define SEG_SHIFT 4
`define OP_BTS 4'h0
`define OP_BTR 4'h1
`define OP_BTC 4'h2
`define OP_ALU 4'h3
`define OP_UNARY 4'h4
`define OP_EXCHANGE_OP 4'h5
`define OP_OTHER 4'hf
`endif

// *** verification/irq_source.sv ***
`timescale 1ns/1ns
// Pins move on the falling edge so the unit's synchroniser sees clean levels
module irq_source
(
   input wire clock,
   input wire nmi_req,
   input wire maskable_interrupt_input_req,
   output logic nmi_pin = 1'b0,
   output logic maskable_interrupt_input = 1'b0
);
   always @(negedge clock)
   begin
      nmi_pin <= nmi_req;
      maskable_interrupt_input <= maskable_interrupt_input_req;
   end
endmodule // irq_source

// *** verification/real_mode_props.sv ***
`timescale 1ns/1ns
`include "real_mode_map.vh"
module real_mode_props
(
   input wire clock,
   input wire rst,
   input wire req_valid,
   input wire [1:0] req_kind,
   input wire [15:0] segment_value,
   input wire [31:0] effective_address,
   input wire [2:0] access_size,
   input wire [3:0] op_form,
   input wire mem_is_dest,
   input wire rep_prefix,
   input wire stack_push_kind,
   input wire [15:0] stack_pointer,
   input wire [15:0] idt_limit,
   input wire [31:0] phys_address,
   input wire [17:0] word_address_lines,
   input wire address_valid,
   input wire bus_locked,
   input wire exception_valid,
   input wire [7:0] exception_vector,
   input wire halted,
   input wire shutdown,
   input wire bus_released,
   input wire paging_enabled,
   input wire real_mode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      req_valid && !halted && !shutdown;
   endsequence
   sequence s_ok_lock;
      s_take ##0 req_kind == 2'd1 && op_form <= `OP_EXCHANGE_OP && mem_is_dest && !rep_prefix && effective_address < 32'hfff0;
   endsequence
   a_mode_fixed: assert property (real_mode && !paging_enabled) else $error("mode wrong");
   a_phys_sum: assert property (address_valid |->
      phys_address == 32'($past(segment_value)) * 16 + $past(effective_address)) else $error("address sum");
   a_word_lines: assert property (address_valid |->
      word_address_lines == phys_address[19:2] && phys_address <= 32'h0010ffef) else $error("word lines");
   a_no_exc: assert property (exception_valid |->
      !(exception_vector inside {8'h0a, 8'h0b, 8'h0e})) else $error("bad vector");
   a_halt_quiet: assert property (halted |-> bus_released && !address_valid) else $error("halt bus");
   a_lock_hold: assert property (s_ok_lock |=> bus_locked && !exception_valid) else $error("lock");
   a_lock_bad: assert property (s_take ##0 req_kind == 2'd1 && op_form == `OP_OTHER |=>
      exception_valid && exception_vector == `EXC_INVALID_OP) else $error("lock form");
   a_wrap_shut: assert property (s_take ##0 stack_push_kind && stack_pointer == 16'h0001 |=> shutdown)
      else $error("wrap");
   a_stuck_shut: assert property (shutdown && idt_limit < `NMI_LIMIT_MIN |=> shutdown) else $error("exit");
   a_seg_overrun: assert property (s_take ##0 req_kind == 2'd0 && effective_address == 32'h0000ffff &&
      access_size == 3'd2 |=> exception_valid && exception_vector inside {`EXC_STACK, `EXC_GENERAL})
      else $error("overrun");
endmodule // real_mode_props
bind real_mode_unit real_mode_props chk_u (.clock, .rst, .req_valid, .req_kind, .segment_value, .effective_address,
   .access_size, .op_form, .mem_is_dest, .rep_prefix, .stack_push_kind, .stack_pointer, .idt_limit, .phys_address,
   .word_address_lines, .address_valid, .bus_locked, .exception_valid, .exception_vector, .halted, .shutdown,
   .bus_released, .paging_enabled, .real_mode);

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`include "real_mode_map.vh"
module tb_top;
   logic clock = 0, rst = 1, clock_enable = 1, req_valid = 0, addr32_prefix = 0, operand32_prefix = 0;
   logic is_code_fetch = 0, is_stack_ref = 0, far_transfer = 0, atomic_prefix = 0, mem_is_dest = 0, rep_prefix = 0;
   logic halt_instruction = 0, stack_push_kind = 0, fault_request = 0, interrupt_enable = 0, nmi_req = 0, maskable_interrupt_input_req = 0;
   logic [1:0] req_kind = 0, io_privilege_level = 0;
   logic [2:0] access_size = 1;
   logic [3:0] op_form = 0;
   logic [7:0] fault_vector = 0;
   logic [15:0] segment_value = 0, next_code_offset = 0, stack_pointer = 16'h0100, idt_limit = 16'h03ff;
   logic [31:0] effective_address = 0;
   wire nmi_pin, maskable_interrupt_input, address_valid, bus_locked, operand_32, exception_valid;
   wire halted, shutdown, bus_released, paging_enabled, real_mode;
   wire [31:0] phys_address;
   wire [17:0] word_address_lines;
   wire [3:0] byte_enable_lines;
   wire [11:0] upper_address_lines;
   wire [7:0] exception_vector;
   wire [15:0] code_pointer_pair;
   wire [19:0] vector_address;
   int bad_count = 0;
   int n_tests = 0;
   int i;
   real_mode_unit dut_u (.*);
   irq_source irq_u (.clock, .nmi_req, .maskable_interrupt_input_req, .nmi_pin, .maskable_interrupt_input);
   initial
   begin
      forever #4 clock = ~clock;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Answer appears at the taking edge and is read at the falling edge after it
   task send(input logic [1:0] k, input logic [15:0] s, input logic [31:0] ea, input logic [2:0] sz);
      @(negedge clock);
      req_kind = k;
      segment_value = s;
      effective_address = ea;
      access_size = sz;
      req_valid = 1;
      @(negedge clock);
      req_valid = 0;
   endtask
   task t_addr;
      chk({real_mode, paging_enabled, upper_address_lines}, 14'h2fff);
      is_code_fetch = 1;
      send(0, 16'hf000, 32'h0000fff0, 1);
      chk(phys_address, 32'h000ffff0);
      chk(upper_address_lines, 12'hfff);
      is_code_fetch = 0;
      far_transfer = 1;
      operand32_prefix = 1;
      send(0, 16'h1000, 32'h10, 2);
      far_transfer = 0;
      operand32_prefix = 0;
      chk({operand_32, phys_address}, 33'h100010010);
      chk(word_address_lines, 18'h04004);
      is_code_fetch = 1;
      send(0, 16'hffff, 32'h0000ffff, 1);
      is_code_fetch = 0;
      chk({operand_32, upper_address_lines, phys_address}, 45'h0000010ffef);
   endtask
   task t_fault;
      send(0, 16'h2000, 32'h0000ffff, 2);
      chk({exception_valid, exception_vector}, 9'h10d);
      is_stack_ref = 1;
      send(0, 16'h2000, 32'h0000ffff, 2);
      is_stack_ref = 0;
      chk({exception_valid, exception_vector}, 9'h10c);
      addr32_prefix = 1;
      send(0, 16'h2000, 32'h00012345, 1);
      addr32_prefix = 0;
      chk({exception_valid, exception_vector}, 9'h10d);
      fault_vector = 8'h21;
      send(3, 0, 32'h84, 1);
      chk(vector_address, 20'h00084);
      idt_limit = 16'h0040;
      send(3, 0, 32'h84, 1);
      idt_limit = 16'h03ff;
      chk({exception_valid, exception_vector}, 9'h108);
   endtask
   task t_lock;
      for (i = 0; i < 6; i++)
      begin
         op_form = 4'(i);
         mem_is_dest = 1;
         io_privilege_level = 2'(i);
         send(1, 16'h3000, 32'h20, 2);
         chk({exception_valid, bus_locked}, 2'b01);
         send(2, 16'h3000, 32'h20, 2);
         chk(exception_valid, 0);
      end
      for (i = 0; i < 3; i++)
      begin
         op_form = (i == 0) ? `OP_OTHER : `OP_ALU;
         mem_is_dest = (i != 1);
         rep_prefix = (i == 2);
         send(1, 16'h3000, 32'h20, 2);
         chk({exception_valid, exception_vector}, 9'h106);
      end
      rep_prefix = 0;
   endtask
   task t_halt;
      next_code_offset = 16'h1234;
      halt_instruction = 1;
      @(negedge clock);
      halt_instruction = 0;
      chk({halted, bus_released}, 2'b11);
      maskable_interrupt_input_req = 1;
      repeat (6) @(negedge clock);
      maskable_interrupt_input_req = 0;
      chk(halted, 1);
      nmi_req = 1;
      for (i = 0; i < 10 && exception_valid !== 1'b1; i++)
         @(negedge clock);
      nmi_req = 0;
      chk({exception_valid, exception_vector, code_pointer_pair}, 25'h1021234);
      halt_instruction = 1;
      interrupt_enable = 1;
      @(negedge clock);
      halt_instruction = 0;
      maskable_interrupt_input_req = 1;
      for (i = 0; i < 10 && exception_valid !== 1'b1; i++)
         @(negedge clock);
      maskable_interrupt_input_req = 0;
      interrupt_enable = 0;
      chk({exception_valid, exception_vector, halted}, 10'h200);
   endtask
   task t_shut;
      stack_pointer = 16'h0001;
      stack_push_kind = 1;
      idt_limit = 16'h0010;
      send(0, 16'h4000, 32'h0, 2);
      stack_push_kind = 0;
      nmi_req = 1;
      repeat (6) @(negedge clock);
      nmi_req = 0;
      chk(shutdown, 1);
      rst = 1;
      repeat (2) @(negedge clock);
      rst = 0;
      chk(shutdown, 0);
      fault_request = 1;
      fault_vector = 8'h08;
      @(negedge clock);
      fault_request = 0;
      @(negedge clock);
      chk(shutdown, 1);
      idt_limit = 16'h0017;
      stack_pointer = 16'h0006;
      nmi_req = 1;
      for (i = 0; i < 10 && shutdown !== 1'b0; i++)
         @(negedge clock);
      nmi_req = 0;
      chk(shutdown, 0);
      idt_limit = 16'h0010;
      fault_vector = 8'h21;
      send(3, 0, 32'h84, 1);
      chk(shutdown, 1);
   endtask
   initial
   begin
      repeat (8) @(negedge clock);
      rst = 0;
      t_addr;
      t_fault;
      t_lock;
      t_halt;
      t_shut;
      results;
   end
   initial
   begin
      #20000;
      bad_count++;
      results;
   end
endmodule // tb_top
